// File: verilog/vcap_pkg.sv
// Shared constants, types and helpers for the video capture input port.
`default_nettype none
package vcap_pkg;
    localparam int ADDR_W   = 24;
    localparam int DATA_W   = 16;
    localparam int FIFO_AW  = 5;
    localparam int FIFO_LIM = 24;

    localparam logic [7:0] OFS_CTRL       = 8'h96;
    localparam logic [7:0] OFS_STATUS     = 8'h97;
    localparam logic [7:0] OFS_MASK_LO    = 8'h98;
    localparam logic [7:0] OFS_MASK_MID   = 8'h99;
    localparam logic [7:0] OFS_MASK_HI    = 8'h9a;
    localparam logic [7:0] OFS_START_LO   = 8'h9c;
    localparam logic [7:0] OFS_START_MID  = 8'h9d;
    localparam logic [7:0] OFS_START_HI   = 8'h9e;
    localparam logic [7:0] OFS_PITCH      = 8'h9f;

    localparam int STAT_OVERFLOW  = 0;
    localparam int STAT_FIELD     = 1;
    localparam int STAT_PENDING   = 2;
    localparam int STAT_BUSY      = 3;

    localparam logic [7:0]        CTRL_RESET  = 8'h00;
    localparam logic [ADDR_W-1:0] START_RESET = 24'h000000;
    localparam logic [7:0]        PITCH_RESET = 8'h00;
    localparam logic [ADDR_W-1:0] MASK_RESET  = 24'h000000;
    localparam logic [ADDR_W-1:0] WORD_STEP   = 24'h000002;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } vcap_word_t;

    typedef struct packed {
        logic              req;
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } vcap_mem_req_t;

    typedef struct packed {
        logic       enable;
        logic       hodd;
        logic [1:0] hdec;
        logic       vodd;
        logic [1:0] vdec;
        logic       mask_en;
    } vcap_ctrl_t;

    function automatic logic [FIFO_AW:0] vcap_gray2bin(input logic [FIFO_AW:0] g);
        logic [FIFO_AW:0] b;
        b = '0;
        for (int i = FIFO_AW; i >= 0; i--) begin
            b[i] = (i == FIFO_AW) ? g[i] : (b[i+1] ^ g[i]);
        end
        return b;
    endfunction : vcap_gray2bin

    function automatic logic [FIFO_AW:0] vcap_bin2gray(input logic [FIFO_AW:0] b);
        return b ^ (b >> 1);
    endfunction : vcap_bin2gray

    // Keep test for one line or pixel out of 1, 2, 4 or 8.
    function automatic logic vcap_keep(input logic [1:0] ratio, input logic odd,
                                       input logic [2:0] cnt);
        logic [2:0] m;
        m = 3'h0;
        case (ratio)
            2'h1:    m = 3'h1;
            2'h2:    m = 3'h3;
            2'h3:    m = 3'h7;
            default: m = 3'h0;
        endcase
        return (cnt & m) == (odd ? 3'h0 : m);
    endfunction : vcap_keep
endpackage : vcap_pkg
`default_nettype wire

// File: verilog/vcap_async_fifo.sv
// Dual-clock word buffer with gray-coded pointers and a fill limit.
`timescale 1ns/1ps
`default_nettype none
module vcap_async_fifo
    import vcap_pkg::*;
#(
    parameter int WIDTH = 40,
    parameter int LIMIT = FIFO_LIM
) (
    // Write side.
    input  wire logic             wclk,
    input  wire logic             wrst,
    input  wire logic             w_valid,
    input  wire logic [WIDTH-1:0] w_data,
    output logic                  w_ready,
    // Read side.
    input  wire logic             clock,
    input  wire logic             srst,
    output logic                  r_valid,
    output logic      [WIDTH-1:0] r_data,
    input  wire logic             r_ready
);
    logic [WIDTH-1:0] mem [2**FIFO_AW];
    logic [FIFO_AW:0] wbin_reg;
    logic [FIFO_AW:0] wgray_reg;
    logic [FIFO_AW:0] rbin_reg;
    logic [FIFO_AW:0] rgray_reg;
    logic [FIFO_AW:0] rg_s1_reg;
    logic [FIFO_AW:0] rg_s2_reg;
    logic [FIFO_AW:0] wg_s1_reg;
    logic [FIFO_AW:0] wg_s2_reg;
    logic [FIFO_AW:0] level;

    // Only gray pointers cross, so a sampled pointer is off by at most one step.
    always_ff @(posedge wclk) begin
        if (wrst) begin
            rg_s1_reg <= '0;
            rg_s2_reg <= '0;
        end else begin
            rg_s1_reg <= rgray_reg;
            rg_s2_reg <= rg_s1_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            wg_s1_reg <= '0;
            wg_s2_reg <= '0;
        end else begin
            wg_s1_reg <= wgray_reg;
            wg_s2_reg <= wg_s1_reg;
        end
    end

    // The limit keeps the usable depth at the 24 words of a 48-byte buffer.
    assign level   = wbin_reg - vcap_gray2bin(rg_s2_reg);
    assign w_ready = level < (FIFO_AW+1)'(LIMIT);

    always_ff @(posedge wclk) begin
        if (w_valid && w_ready) begin
            mem[wbin_reg[FIFO_AW-1:0]] <= w_data;
        end
    end

    always_ff @(posedge wclk) begin
        if (wrst) begin
            wbin_reg  <= '0;
            wgray_reg <= '0;
        end else if (w_valid && w_ready) begin
            wbin_reg  <= wbin_reg + 1'b1;
            wgray_reg <= vcap_bin2gray(wbin_reg + 1'b1);
        end
    end

    assign r_valid = rgray_reg != wg_s2_reg;
    assign r_data  = mem[rbin_reg[FIFO_AW-1:0]];

    always_ff @(posedge clock) begin
        if (srst) begin
            rbin_reg  <= '0;
            rgray_reg <= '0;
        end else if (r_valid && r_ready) begin
            rbin_reg  <= rbin_reg + 1'b1;
            rgray_reg <= vcap_bin2gray(rbin_reg + 1'b1);
        end
    end
endmodule : vcap_async_fifo
`default_nettype wire

// File: verilog/vcap_arbiter.sv
// Fixed-priority memory arbiter: refresh, then capture port, then the rest.
`timescale 1ns/1ps
`default_nettype none
module vcap_arbiter (
    // Requests.
    input  wire logic refresh_req,
    input  wire logic port_req,
    input  wire logic other_req,
    input  wire logic mem_ready,
    // Grants.
    output logic      refresh_gnt,
    output logic      port_gnt,
    output logic      other_gnt
);
    assign refresh_gnt = mem_ready && refresh_req;
    assign port_gnt    = mem_ready && port_req && !refresh_req;
    assign other_gnt   = mem_ready && other_req && !refresh_req && !port_req;
endmodule : vcap_arbiter
`default_nettype wire

// File: verilog/vcap_input_port.sv
// Video capture input port: pixel link, capture addressing and frame buffer writer.
// Operation
// - 16-bit port on source clock, 33 MHz
// - Optional vertical decimation by 2, 4, 8
// - Optional horizontal decimation by 2, 4, 8
// - Start address held in bytes 9C-9E
// - Line pitch register at byte 9F
// - Frame start loads start address
// - End of a kept line adds pitch to line start
// - Each kept valid word not on a strobe cycle goes to frame buffer unless the buffer is full
// - Words pass a 48-byte buffer to memory
// - Arbiter: refresh, then port, then others
// - Mask bit zero suppresses the pixel write
// - Mask map fetched from programmable start address
`timescale 1ns/1ps
`default_nettype none
module vcap_input_port
    import vcap_pkg::*;
(
    // System clock and reset.
    input  wire logic              clock,
    input  wire logic              srst,
    // Register port.
    input  wire logic              reg_wr_en,
    input  wire logic              reg_rd_en,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    output logic      [7:0]        reg_rdata,
    // Video link.
    input  wire logic              video_in_clock,
    input  wire logic              frame_start_n,
    input  wire logic              line_end_n,
    input  wire logic              pixel_valid,
    input  wire logic              field_parity,
    input  wire logic [DATA_W-1:0] video_in_data,
    // Memory arbitration.
    input  wire logic              mem_ready,
    input  wire logic              refresh_req,
    input  wire logic              other_req,
    output logic                   refresh_gnt,
    output logic                   other_gnt,
    output logic                   port_gnt,
    // Capture port memory request.
    output logic                   cap_req,
    output logic                   cap_we,
    output logic      [ADDR_W-1:0] cap_addr,
    output logic      [DATA_W-1:0] cap_wdata,
    input  wire logic              mem_rvalid,
    input  wire logic [7:0]        mem_rdata
);
    typedef enum logic [1:0] {
        VCAP_IDLE      = 2'b00,
        VCAP_MASK_REQ  = 2'b01,
        VCAP_MASK_WAIT = 2'b10,
        VCAP_WRITE     = 2'b11
    } vcap_state_t;

    vcap_ctrl_t        ctrl_reg;
    logic [ADDR_W-1:0] start_reg;
    logic [7:0]        pitch_reg;
    logic [ADDR_W-1:0] mask_start_reg;

    // Byte-wide register file.
    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl_reg       <= CTRL_RESET;
            start_reg      <= START_RESET;
            pitch_reg      <= PITCH_RESET;
            mask_start_reg <= MASK_RESET;
        end else if (reg_wr_en) begin
            case (reg_addr)
                OFS_CTRL:      ctrl_reg             <= reg_wdata;
                OFS_MASK_LO:   mask_start_reg[7:0]  <= reg_wdata;
                OFS_MASK_MID:  mask_start_reg[15:8] <= reg_wdata;
                OFS_MASK_HI:   mask_start_reg[23:16] <= reg_wdata;
                OFS_START_LO:  start_reg[7:0]       <= reg_wdata;
                OFS_START_MID: start_reg[15:8]      <= reg_wdata;
                OFS_START_HI:  start_reg[23:16]     <= reg_wdata;
                OFS_PITCH:     pitch_reg            <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Video domain reset and quasi-static settings, each through two flops.
    // Settings must be written while no frame is running; a mid-frame change
    // may be seen bit by bit over one or two link clocks.
    localparam int CFG_W = 1 + 8 + 8 + ADDR_W;
    logic [CFG_W-1:0]  cfg_s1_reg;
    logic [CFG_W-1:0]  cfg_s2_reg;
    logic              vrst_s1_reg;
    logic              vrst_reg;
    vcap_ctrl_t        v_ctrl;
    logic [7:0]        v_pitch;
    logic [ADDR_W-1:0] v_start;

    always_ff @(posedge video_in_clock) begin
        vrst_s1_reg <= srst;
        vrst_reg    <= vrst_s1_reg;
        cfg_s1_reg  <= {1'b0, ctrl_reg, pitch_reg, start_reg};
        cfg_s2_reg  <= cfg_s1_reg;
    end
    assign {v_ctrl, v_pitch, v_start} = cfg_s2_reg[CFG_W-2:0];

    // Link side, on the link's own clock.
    logic              fs_n_d_reg;
    logic              le_n_d_reg;
    logic [ADDR_W-1:0] line_start_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [2:0]        line_cnt_reg;
    logic [2:0]        pix_cnt_reg;
    logic              field_v_reg;
    logic              ovf_v_reg;
    logic              frame_on_reg;
    logic              fs_pulse;
    logic              le_pulse;
    logic              line_keep;
    logic              pix_keep;
    logic              push;
    logic              f_w_ready;
    logic [ADDR_W-1:0] next_line;
    vcap_word_t        push_word;

    assign fs_pulse  = !frame_start_n && fs_n_d_reg;
    assign le_pulse  = !line_end_n && le_n_d_reg;
    assign line_keep = vcap_keep(v_ctrl.vdec, v_ctrl.vodd, line_cnt_reg);
    assign pix_keep  = vcap_keep(v_ctrl.hdec, v_ctrl.hodd, pix_cnt_reg);
    assign push      = frame_on_reg && pixel_valid && !fs_pulse && !le_pulse
                       && line_keep && pix_keep;
    assign next_line = line_start_reg + {16'h0000, v_pitch};
    assign push_word = '{addr: addr_reg, data: video_in_data};

    always_ff @(posedge video_in_clock) begin
        if (vrst_reg) begin
            fs_n_d_reg <= 1'b1;
            le_n_d_reg <= 1'b1;
        end else begin
            fs_n_d_reg <= frame_start_n;
            le_n_d_reg <= line_end_n;
        end
    end

    always_ff @(posedge video_in_clock) begin
        if (vrst_reg) begin
            frame_on_reg <= 1'b0;
        end else if (fs_pulse) begin
            frame_on_reg <= v_ctrl.enable;
        end
    end

    // Dropped lines do not move the line start, so decimated lines pack tightly.
    always_ff @(posedge video_in_clock) begin
        if (vrst_reg) begin
            line_start_reg <= START_RESET;
            addr_reg       <= START_RESET;
            line_cnt_reg   <= 3'h0;
            pix_cnt_reg    <= 3'h0;
        end else if (fs_pulse) begin
            line_start_reg <= v_start;
            addr_reg       <= v_start;
            line_cnt_reg   <= 3'h0;
            pix_cnt_reg    <= 3'h0;
        end else if (le_pulse) begin
            if (line_keep) begin
                line_start_reg <= next_line;
                addr_reg       <= next_line;
            end else begin
                addr_reg <= line_start_reg;
            end
            line_cnt_reg <= line_cnt_reg + 3'h1;
            pix_cnt_reg  <= 3'h0;
        end else if (frame_on_reg && pixel_valid) begin
            pix_cnt_reg <= pix_cnt_reg + 3'h1;
            if (push && f_w_ready) begin
                addr_reg <= addr_reg + WORD_STEP;
            end
        end
    end

    // Overflow is sticky until the next frame start.
    always_ff @(posedge video_in_clock) begin
        if (vrst_reg) begin
            ovf_v_reg   <= 1'b0;
            field_v_reg <= 1'b0;
        end else begin
            field_v_reg <= field_parity;
            if (fs_pulse) begin
                ovf_v_reg <= 1'b0;
            end else if (push && !f_w_ready) begin
                ovf_v_reg <= 1'b1;
            end
        end
    end

    // Crossing buffer between link and memory.
    vcap_word_t pop_word;
    logic       f_r_valid;
    logic       f_r_ready;

    vcap_async_fifo #(
        .WIDTH ($bits(vcap_word_t)),
        .LIMIT (FIFO_LIM)
    ) u_fifo (
        .wclk    (video_in_clock),
        .wrst    (vrst_reg),
        .w_valid (push),
        .w_data  (push_word),
        .w_ready (f_w_ready),
        .clock   (clock),
        .srst    (srst),
        .r_valid (f_r_valid),
        .r_data  (pop_word),
        .r_ready (f_r_ready)
    );

    vcap_arbiter u_arb (
        .refresh_req (refresh_req),
        .port_req    (cap_req),
        .other_req   (other_req),
        .mem_ready   (mem_ready),
        .refresh_gnt (refresh_gnt),
        .port_gnt    (port_gnt),
        .other_gnt   (other_gnt)
    );

    // Memory side writer.
    vcap_state_t   state_reg;
    vcap_word_t    cur_reg;
    vcap_mem_req_t mreq_reg;
    logic [2:0]    mbit_reg;
    logic [ADDR_W-1:0] mask_addr;

    // One mask bit per 16-bit pixel, contiguous from the map's start address.
    assign mask_addr = mask_start_reg + {4'h0, pop_word.addr[ADDR_W-1:4]};
    assign f_r_ready = (state_reg == VCAP_IDLE);
    assign cap_req   = mreq_reg.req;
    assign cap_we    = mreq_reg.we;
    assign cap_addr  = mreq_reg.addr;
    assign cap_wdata = mreq_reg.wdata;

    always_ff @(posedge clock) begin
        if (srst) begin
            state_reg <= VCAP_IDLE;
            cur_reg   <= '0;
            mbit_reg  <= 3'h0;
            mreq_reg  <= '0;
        end else begin
            case (state_reg)
                VCAP_IDLE: begin
                    if (f_r_valid) begin
                        cur_reg  <= pop_word;
                        mbit_reg <= pop_word.addr[3:1];
                        if (ctrl_reg.mask_en) begin
                            mreq_reg  <= '{req: 1'b1, we: 1'b0, addr: mask_addr, wdata: '0};
                            state_reg <= VCAP_MASK_REQ;
                        end else begin
                            mreq_reg  <= '{req: 1'b1, we: 1'b1, addr: pop_word.addr,
                                           wdata: pop_word.data};
                            state_reg <= VCAP_WRITE;
                        end
                    end
                end
                VCAP_MASK_REQ: begin
                    if (port_gnt) begin
                        mreq_reg.req <= 1'b0;
                        state_reg    <= VCAP_MASK_WAIT;
                    end
                end
                VCAP_MASK_WAIT: begin
                    if (mem_rvalid) begin
                        if (mem_rdata[mbit_reg]) begin
                            mreq_reg  <= '{req: 1'b1, we: 1'b1, addr: cur_reg.addr,
                                           wdata: cur_reg.data};
                            state_reg <= VCAP_WRITE;
                        end else begin
                            state_reg <= VCAP_IDLE;
                        end
                    end
                end
                VCAP_WRITE: begin
                    if (port_gnt) begin
                        mreq_reg.req <= 1'b0;
                        state_reg    <= VCAP_IDLE;
                    end
                end
                default: state_reg <= VCAP_IDLE;
            endcase
        end
    end

    // Status levels brought over from the link side.
    logic [1:0] st_s1_reg;
    logic [1:0] st_s2_reg;

    always_ff @(posedge clock) begin
        if (srst) begin
            st_s1_reg <= 2'h0;
            st_s2_reg <= 2'h0;
        end else begin
            st_s1_reg <= {field_v_reg, ovf_v_reg};
            st_s2_reg <= st_s1_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd_en) begin
            case (reg_addr)
                OFS_CTRL:      reg_rdata <= ctrl_reg;
                OFS_STATUS:    reg_rdata <= {4'h0, state_reg != VCAP_IDLE, f_r_valid,
                                             st_s2_reg[1], st_s2_reg[0]};
                OFS_MASK_LO:   reg_rdata <= mask_start_reg[7:0];
                OFS_MASK_MID:  reg_rdata <= mask_start_reg[15:8];
                OFS_MASK_HI:   reg_rdata <= mask_start_reg[23:16];
                OFS_START_LO:  reg_rdata <= start_reg[7:0];
                OFS_START_MID: reg_rdata <= start_reg[15:8];
                OFS_START_HI:  reg_rdata <= start_reg[23:16];
                OFS_PITCH:     reg_rdata <= pitch_reg;
                default:       reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule : vcap_input_port
`default_nettype wire

// File: dv/vcap_chk.sv
// Checker for arbitration, memory request and register read timing.
`timescale 1ns/1ps
`default_nettype none
module vcap_chk
    import vcap_pkg::*;
(
    // Clock and reset.
    input wire logic              clock,
    input wire logic              srst,
    // Register port.
    input wire logic              reg_wr_en,
    input wire logic              reg_rd_en,
    input wire logic [7:0]        reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic [7:0]        reg_rdata,
    // Memory side.
    input wire logic              mem_ready,
    input wire logic              refresh_req,
    input wire logic              other_req,
    input wire logic              refresh_gnt,
    input wire logic              other_gnt,
    input wire logic              port_gnt,
    input wire logic              cap_req,
    input wire logic              cap_we,
    input wire logic [ADDR_W-1:0] cap_addr,
    input wire logic [DATA_W-1:0] cap_wdata
);
    logic [7:0] pitch_q;

    // Shadow of the pitch byte, so a read can be tied to the last write.
    always_ff @(posedge clock) begin
        if (srst) begin
            pitch_q <= 8'h00;
        end else if (reg_wr_en && reg_addr == OFS_PITCH) begin
            pitch_q <= reg_wdata;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (srst);

    sequence s_wait;
        cap_req && !port_gnt;
    endsequence
    sequence s_grant;
        cap_req && port_gnt;
    endsequence

    a_refresh_first: assert property (refresh_req && mem_ready |->
        refresh_gnt && !port_gnt && !other_gnt) else $error("refresh not first");
    a_port_second: assert property (cap_req && mem_ready && !refresh_req |->
        port_gnt && !other_gnt) else $error("port not second");
    a_other_last: assert property (other_gnt |->
        other_req && mem_ready && !refresh_req && !cap_req) else $error("other out of turn");
    a_ready_gates_gnt: assert property (!mem_ready |->
        !refresh_gnt && !port_gnt && !other_gnt) else $error("grant without ready");
    a_req_stands: assert property (s_wait |=> cap_req && $stable(cap_addr)
        && $stable(cap_wdata) && $stable(cap_we)) else $error("request moved");
    a_req_drops: assert property (s_grant |=> !cap_req)
        else $error("request held");
    a_pitch_read: assert property (reg_rd_en && reg_addr == OFS_PITCH |=>
        reg_rdata == $past(pitch_q)) else $error("pitch read wrong");
    a_rdata_holds: assert property (!reg_rd_en |=> $stable(reg_rdata))
        else $error("read data moved");
endmodule : vcap_chk

bind vcap_input_port vcap_chk u_chk (.clock(clock), .srst(srst), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .mem_ready(mem_ready), .refresh_req(refresh_req), .other_req(other_req),
    .refresh_gnt(refresh_gnt), .other_gnt(other_gnt), .port_gnt(port_gnt), .cap_req(cap_req),
    .cap_we(cap_we), .cap_addr(cap_addr), .cap_wdata(cap_wdata));
`default_nettype wire

// File: dv/vcap_src_model.sv
// Behavioural video source that drives the capture link on its own clock.
`timescale 1ns/1ps
`default_nettype none
module vcap_src_model
    import vcap_pkg::*;
(
    // Link outputs.
    output logic              video_in_clock,
    output logic              frame_start_n,
    output logic              line_end_n,
    output logic              pixel_valid,
    output logic              field_parity,
    output logic [DATA_W-1:0] video_in_data
);
    // The clock runs free, since the link reset needs edges while reset is held.
    initial begin
        video_in_clock = 1'b0;
        {frame_start_n, line_end_n, pixel_valid, field_parity} = 4'hc;
        video_in_data = 16'h0000;
        #7;
        forever #15 video_in_clock = ~video_in_clock;
    end

    // One strobed link cycle, then one idle cycle with the data bus scrambled.
    task automatic cyc(input logic fs, input logic le, input logic v, input int d);
        @(negedge video_in_clock);
        frame_start_n <= !fs;
        line_end_n <= !le;
        pixel_valid <= v;
        video_in_data <= d[DATA_W-1:0];
        field_parity <= field_parity ^ fs;
        @(negedge video_in_clock);
        frame_start_n <= 1'b1;
        line_end_n <= 1'b1;
        pixel_valid <= 1'b0;
        video_in_data <= ~d[DATA_W-1:0];
    endtask : cyc
endmodule : vcap_src_model
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the video capture input port.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import vcap_pkg::*;
;
    localparam int S = 24'h001000;
    localparam int P = 8'h40;
    localparam int M = 24'h010000;
    logic              clock, srst, reg_wr_en, reg_rd_en, mem_ready, refresh_req, other_req;
    logic              refresh_gnt, other_gnt, port_gnt, cap_req, cap_we, mem_rvalid, mwr, mrd;
    logic              vclk, fs_n, le_n, pv, fp;
    logic [7:0]        reg_addr, reg_wdata, reg_rdata, mem_rdata, v;
    logic [DATA_W-1:0] vdata, cap_wdata;
    logic [ADDR_W-1:0] cap_addr, rd_addr;
    logic [39:0]       got_q[$], exp_q[$];
    int                fail_count, cmp_count;

    vcap_input_port DUT (.clock(clock), .srst(srst), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .video_in_clock(vclk), .frame_start_n(fs_n),
        .line_end_n(le_n), .pixel_valid(pv), .field_parity(fp), .video_in_data(vdata),
        .mem_ready(mem_ready), .refresh_req(refresh_req), .other_req(other_req),
        .refresh_gnt(refresh_gnt), .other_gnt(other_gnt), .port_gnt(port_gnt),
        .cap_req(cap_req), .cap_we(cap_we), .cap_addr(cap_addr), .cap_wdata(cap_wdata),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
    vcap_src_model src (.video_in_clock(vclk), .frame_start_n(fs_n), .line_end_n(le_n),
        .pixel_valid(pv), .field_parity(fp), .video_in_data(vdata));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Frame buffer: logs writes, answers mask reads.
    assign mwr = cap_req === 1'b1 && port_gnt === 1'b1 && cap_we === 1'b1;
    assign mrd = cap_req === 1'b1 && port_gnt === 1'b1 && cap_we === 1'b0;
    always @(posedge clock) begin
        mem_rvalid <= mrd;
        mem_rdata <= mrd ? 8'h05 : 8'hfa;
        if (mwr) got_q.push_back({cap_addr, cap_wdata});
        if (mrd) rd_addr = cap_addr;
    end

    task automatic summarize();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [39:0] g, input logic [39:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input int d);
        @(negedge clock);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d[7:0];
        @(negedge clock);
        reg_wr_en = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge clock);
        reg_rd_en = 1'b0;
        d = reg_rdata;
    endtask : rd

    task automatic set24(input logic [7:0] a, input int d);
        wr(a, d);
        wr(a + 8'h01, d >> 8);
        wr(a + 8'h02, d >> 16);
    endtask : set24

    task automatic ex(input int a, input int d);
        exp_q.push_back({a[ADDR_W-1:0], d[DATA_W-1:0]});
    endtask : ex

    // Wait for the expected writes, then compare them in order.
    task automatic flush(input string name);
        int n;
        n = 0;
        while (got_q.size() < exp_q.size() && n < 3000) begin
            @(negedge clock);
            n++;
        end
        if (n == 3000) begin
            fail_count++;
            summarize();
        end
        repeat (40) @(negedge clock);
        chk(got_q.size(), exp_q.size());
        while (got_q.size() > 0 && exp_q.size() > 0) chk(got_q.pop_front(), exp_q.pop_front());
        got_q.delete();
        exp_q.delete();
        $display("Test %s done", name);
    endtask : flush

    initial begin
        {srst, reg_wr_en, reg_rd_en, mem_ready, refresh_req, other_req} = 6'h24;
        {reg_addr, reg_wdata} = 16'h0;
        fail_count = 0;
        cmp_count = 0;
        repeat (5) @(negedge clock);
        srst = 1'b0;
        for (int i = 0; i < 5; i++) begin
            rd(8'h9b + i[7:0], v);
            chk(v, 0);
        end
        set24(OFS_START_LO, S);
        wr(OFS_PITCH, P);
        wr(8'h80, 8'h5a);
        rd(OFS_START_MID, v);
        chk(v, 8'h10);
        rd(OFS_PITCH, v);
        chk(v, P);
        rd(8'h80, v);
        chk(v, 0);
        $display("Test registers done");
        wr(OFS_CTRL, 8'h80);
        {refresh_req, other_req} = 2'b11;
        repeat (10) @(negedge clock);
        src.cyc(1, 0, 0, 0);
        for (int j = 0; j < 5; j++) begin
            if (j == 3) src.cyc(0, 1, 0, 0);
            src.cyc(0, 0, 1, 16'h0a00 + j);
            ex(S + (j > 2 ? P + 2 * j - 6 : 2 * j), 16'h0a00 + j);
        end
        {refresh_req, other_req} = 2'b00;
        flush("capture");
        set24(OFS_MASK_LO, M);
        wr(OFS_CTRL, 8'h81);
        repeat (10) @(negedge clock);
        src.cyc(1, 0, 0, 0);
        for (int j = 0; j < 4; j++) src.cyc(0, 0, 1, 16'h0c00 + j);
        ex(S, 16'h0c00);
        ex(S + 4, 16'h0c02);
        flush("mask");
        chk(rd_addr, M + (S >> 4));
        for (int r = 1; r <= 3; r++) begin
            wr(OFS_CTRL, 8'hc8 | (r << 4) | (r << 1));
            repeat (10) @(negedge clock);
            src.cyc(1, 0, 0, 0);
            for (int k = 0; k <= (1 << r); k++) begin
                for (int j = 0; j < 8; j++) begin
                    src.cyc(0, 0, 1, (k << 8) | j);
                    if (j % (1 << r) == 0 && k % (1 << r) == 0)
                        ex(S + (k > 0 ? P : 0) + 2 * (j >> r), (k << 8) | j);
                end
                src.cyc(0, 1, 0, 0);
            end
            flush("decimate");
        end
        // One word waits at the memory request, so the buffer itself takes 24 more.
        wr(OFS_CTRL, 8'h80);
        mem_ready = 1'b0;
        repeat (10) @(negedge clock);
        src.cyc(1, 0, 0, 0);
        for (int j = 0; j < 30; j++) begin
            src.cyc(0, 0, 1, j);
            if (j < 25) ex(S + 2 * j, j);
        end
        rd(OFS_STATUS, v);
        chk(v[STAT_OVERFLOW], 1'b1);
        mem_ready = 1'b1;
        flush("overflow");
        summarize();
    end
endmodule : testbench
`default_nettype wire
